// ===== mrp_pkg.sv
package mrp_pkg;

	// ----------------------------------------
	// Geometry
	// ----------------------------------------
	localparam int unsigned ADDR_W       = 32;
	localparam int unsigned SUB_CNT      = 8;
	localparam int unsigned SIZE_CODE_W  = 5;
	localparam int unsigned SUB_SHIFT    = 3;
	// Size code n means 2^(n+1) bytes: 4 is 32 B, 31 is 4 GB
	localparam logic [4:0]  SIZE_CODE_MIN = 5'h04;
	localparam logic [4:0]  SIZE_CODE_MAX = 5'h1f;
	localparam logic [4:0]  SIZE_CODE_SUB = 5'h07;
	localparam logic [4:0]  SIZE_CODE_RST = 5'h04;

	// ----------------------------------------
	// Permission encodings
	// ----------------------------------------
	typedef enum logic [2:0] {
		perm_priv_none_user_none = 3'h0,
		perm_priv_rw_user_none   = 3'h1,
		perm_priv_rw_user_ro     = 3'h2,
		perm_priv_rw_user_rw     = 3'h3,
		perm_priv_ro_user_none   = 3'h5,
		perm_priv_ro_user_ro     = 3'h6
	} mrp_perm_t;

	localparam logic region_exec_allow = 1'b0;
	localparam logic region_exec_deny  = 1'b1;
	localparam logic region_active     = 1'b1;
	localparam logic region_inactive   = 1'b0;

	typedef struct packed {
		logic                   region_active_bit;
		logic [SUB_CNT-1:0]     subregion_off_bit;
		mrp_perm_t              perm;
		logic                   exec_deny;
		logic [SIZE_CODE_W-1:0] region_size_code;
	} mrp_attr_t;

	localparam mrp_attr_t ATTR_RST = '{
		region_active_bit: region_inactive,
		subregion_off_bit: 8'h00,
		perm:              perm_priv_none_user_none,
		exec_deny:         region_exec_allow,
		region_size_code:  SIZE_CODE_RST
	};

	typedef struct packed {
		logic [ADDR_W-1:0] region_base;
		mrp_attr_t         region_attributes;
	} mrp_region_t;

	typedef struct packed {
		logic              valid;
		logic [ADDR_W-1:0] addr;
		logic              write;
		logic              fetch;
		logic              priv;
		logic              fault_handler;
	} mrp_access_t;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_FAULT = 2'b01
	} mrp_state_t;

endpackage

// ===== mrp_region_protect.sv
// Function
// - Enabled regions check accesses, fault on violation
// - Base aligned to size; low bits ignored
// - Size code selects 32B up to 4G
// - Execute deny faults instruction fetches
// - Six encoded priv/user read-write permission choices
// - Region split into eight equal subregions
// - Subregion disables only at 256B or larger
// - Disabled subregion does not match
// - Enable bit stored with other attributes
// - Readback returns base and attributes; a size code below 4 reads back as 4
// - Up to eight regions, count reported
// - Unit disabled: default map, no faults
// - Option: privileged background map on no match
// - Option: protect inside fault handlers
module mrp_region_protect #(
	parameter int unsigned NUM_REGIONS = 8
) (
	input  wire logic                       i_clk,
	input  wire logic                       i_arst_n,
	input  wire logic                       i_ce,
	input  wire logic                       i_unit_enable,
	input  wire logic                       i_privileged_background_map,
	input  wire logic                       i_protect_in_fault_handlers,
	input  wire logic                       i_cfg_write,
	input  wire logic [2:0]                 i_region_number,
	input  wire mrp_pkg::mrp_region_t       i_cfg_region,
	input  wire logic                       i_region_enable_set,
	input  wire logic                       i_region_enable_clr,
	output logic      [3:0]                 o_region_count,
	output mrp_pkg::mrp_region_t            o_cfg_region,
	input  wire mrp_pkg::mrp_access_t       i_access,
	output logic                            o_access_done,
	output logic                            o_access_allowed,
	output logic                            o_mem_fault,
	output logic      [mrp_pkg::ADDR_W-1:0] o_fault_addr
);
	import mrp_pkg::*;

	initial begin
		if (NUM_REGIONS < 1 || NUM_REGIONS > 8)
			$error("NUM_REGIONS must be 1 to 8");
	end

	// ----------------------------------------
	// Decode helpers
	// ----------------------------------------
	// Byte mask of the region span; size code n covers 2^(n+1) bytes
	function automatic logic [ADDR_W-1:0] span_mask(input logic [SIZE_CODE_W-1:0] code);
		logic [ADDR_W:0] m;
		m = '0;
		// Six-bit shift amount so the 4 GB code reaches bit 32 instead of wrapping to zero
		m = ({{ADDR_W{1'b0}}, 1'b1} << ({1'b0, code} + 6'h01)) - 1'b1;
		return m[ADDR_W-1:0];
	endfunction

	function automatic logic perm_ok(input mrp_perm_t p, input logic priv, input logic wr);
		logic ok;
		ok = 1'b0;
		case (p)
			perm_priv_rw_user_none: ok = priv;
			perm_priv_rw_user_ro:   ok = priv | ~wr;
			perm_priv_rw_user_rw:   ok = 1'b1;
			perm_priv_ro_user_none: ok = priv & ~wr;
			perm_priv_ro_user_ro:   ok = ~wr;
			default:                ok = 1'b0;
		endcase
		return ok;
	endfunction

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		mrp_region_t [7:0]  region;
		mrp_state_t         state;
		logic               done;
		logic               allowed;
		logic               fault;
		logic [ADDR_W-1:0]  fault_addr;
		mrp_region_t        rd;
	} mrp_st_t;

	mrp_st_t st_r;
	mrp_st_t st_nxt;

	logic [7:0] hit;
	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_match
			logic [ADDR_W-1:0]          msk;
			logic [SIZE_CODE_W-1:0]     code;
			logic [2:0]                 sub;
			logic [ADDR_W+SUB_SHIFT:0]  sub_wide;
			always_comb begin
				code     = st_r.region[g].region_attributes.region_size_code;
				if (code < SIZE_CODE_MIN)
					code = SIZE_CODE_MIN;
				msk      = span_mask(code);
				// Offset within region divided by one eighth of the span
				sub_wide = {1'b0, i_access.addr & msk, 3'b000} >> ({1'b0, code} + 6'h01);
				sub      = sub_wide[2:0];
				hit[g]   = (g < NUM_REGIONS)
					&& st_r.region[g].region_attributes.region_active_bit
					&& ((i_access.addr & ~msk) == (st_r.region[g].region_base & ~msk))
					&& !((code >= SIZE_CODE_SUB)
						&& st_r.region[g].region_attributes.subregion_off_bit[sub]);
			end
		end
	endgenerate

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		logic      found;
		logic      ok;
		logic      bypass;
		mrp_attr_t a;
		found  = 1'b0;
		ok     = 1'b0;
		a      = ATTR_RST;
		bypass = 1'b0;
		st_nxt = st_r;
		// Ascending scan so the highest numbered hit overrides
		for (int i = 0; i < 8; i++) begin
			if (hit[i]) begin
				found = 1'b1;
				a     = st_r.region[i].region_attributes;
			end
		end
		ok = found && perm_ok(a.perm, i_access.priv, i_access.write)
			&& !(i_access.fetch && a.exec_deny == region_exec_deny);
		if (!found && i_access.priv && i_privileged_background_map)
			ok = 1'b1;
		bypass = !i_unit_enable
			|| (i_access.fault_handler && !i_protect_in_fault_handlers);
		st_nxt.done  = 1'b0;
		st_nxt.fault = 1'b0;
		st_nxt.state = ST_IDLE;
		if (i_access.valid) begin
			st_nxt.done    = 1'b1;
			st_nxt.allowed = bypass || ok;
			if (!(bypass || ok)) begin
				st_nxt.fault      = 1'b1;
				st_nxt.fault_addr = i_access.addr;
				st_nxt.state      = ST_FAULT;
			end
		end
		if (i_cfg_write && i_region_number < NUM_REGIONS) begin
			st_nxt.region[i_region_number] = i_cfg_region;
			if (i_cfg_region.region_attributes.region_size_code < SIZE_CODE_MIN)
				st_nxt.region[i_region_number].region_attributes.region_size_code = SIZE_CODE_MIN;
		end else if (i_region_enable_set && i_region_number < NUM_REGIONS) begin
			st_nxt.region[i_region_number].region_attributes.region_active_bit = region_active;
		end else if (i_region_enable_clr && i_region_number < NUM_REGIONS) begin
			st_nxt.region[i_region_number].region_attributes.region_active_bit = region_inactive;
		end
		st_nxt.rd = (i_region_number < NUM_REGIONS) ? st_nxt.region[i_region_number] : '0;
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			for (int i = 0; i < 8; i++) begin
				st_r.region[i] <= '{region_base: '0, region_attributes: ATTR_RST};
			end
			st_r.state      <= ST_IDLE;
			st_r.done       <= 1'b0;
			st_r.allowed    <= 1'b0;
			st_r.fault      <= 1'b0;
			st_r.fault_addr <= '0;
			st_r.rd         <= '0;
		end else if (i_ce) begin
			st_r <= st_nxt;
		end
	end

	assign o_region_count   = 4'(NUM_REGIONS);
	assign o_cfg_region     = st_r.rd;
	assign o_access_done    = st_r.done;
	assign o_access_allowed = st_r.allowed;
	assign o_mem_fault      = st_r.fault;
	assign o_fault_addr     = st_r.fault_addr;

endmodule

// ===== mrp_rp_props.sv
module mrp_rp_props #(
	parameter int unsigned NUM_REGIONS = 8
) (
	input wire logic                 i_clk,
	input wire logic                 i_arst_n,
	input wire logic                 i_ce,
	input wire logic                 i_unit_enable,
	input wire logic                 i_protect_in_fault_handlers,
	input wire logic                 i_cfg_write,
	input wire logic [2:0]           i_region_number,
	input wire mrp_pkg::mrp_region_t i_cfg_region,
	input wire mrp_pkg::mrp_access_t i_access,
	input wire logic [3:0]           o_region_count,
	input wire mrp_pkg::mrp_region_t o_cfg_region,
	input wire logic                 o_access_done,
	input wire logic                 o_access_allowed,
	input wire logic                 o_mem_fault,
	input wire logic [31:0]          o_fault_addr
);
	import mrp_pkg::*;
	wire take = i_ce && i_access.valid;
	wire fh = take && i_unit_enable && i_access.fault_handler;
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_arst_n);
	// ----
	// Answers
	// ----
	done_one_a: assert property (take |=> o_access_done) else $error("done missing");
	done_cause_a: assert property (o_access_done && $past(i_ce) |-> $past(i_access.valid)) else $error("stray done");
	fault_allow_a: assert property (o_access_done |-> o_mem_fault != o_access_allowed) else $error("verdict split");
	fault_addr_a: assert property (o_mem_fault && $past(i_ce) |-> o_access_done && o_fault_addr == $past(i_access.addr))
		else $error("fault addr wrong");
	unit_off_a: assert property (take && !i_unit_enable |=> o_access_allowed) else $error("fault while off");
	handler_bypass_a: assert property (fh && !i_protect_in_fault_handlers |=> o_access_allowed) else $error("bypass");
	region_count_a: assert property (o_region_count == 4'(NUM_REGIONS)) else $error("count wrong");
	readback_a: assert property (i_ce && i_cfg_write && i_region_number < NUM_REGIONS
		&& i_cfg_region.region_attributes.region_size_code >= SIZE_CODE_MIN |=> o_cfg_region == $past(i_cfg_region))
		else $error("readback differs");
endmodule
bind mrp_region_protect mrp_rp_props #(.NUM_REGIONS(NUM_REGIONS)) props_i (.*);

// ===== mrp_core_model.sv
module mrp_core_model (
	input  wire logic                 i_clk,
	input  wire logic                 i_arst_n,
	input  wire logic                 i_go,
	input  wire mrp_pkg::mrp_access_t i_req,
	output mrp_pkg::mrp_access_t      o_access
);
	import mrp_pkg::*;
	// Idle address flips every cycle so a stale value is never mistaken for a request
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n)
			o_access <= '0;
		else if (i_go)
			o_access <= '{valid: 1'b1, addr: i_req.addr, write: i_req.write, fetch: i_req.fetch,
				priv: i_req.priv, fault_handler: i_req.fault_handler};
		else
			o_access <= '{valid: 1'b0, addr: ~o_access.addr, default: 1'b0};
	end
endmodule

// ===== testbench.sv
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import mrp_pkg::*;
	logic        i_clk, i_arst_n, unit_en, bg, pfh, wr, es, ec, go, fh, done, alw, flt;
	logic [2:0]  num;
	logic [3:0]  cnt;
	logic [31:0] fa;
	mrp_region_t cfg, rb;
	mrp_access_t req, acc;
	int          err_count, total_checks, cyc;
	// Rows: address, then {write, fetch, priv, allowed}
	localparam logic [35:0] ROWS [12] = '{36'h0_0001_000b, 36'h0_0001_0008, 36'h0_0001_0001, 36'h0_0001_0005,
		36'h0_0001_400a, 36'h0_0001_4001, 36'h0_0001_4006, 36'h0_0001_6008, 36'h0_0001_600b,
		36'h0_0003_0002, 36'h0_0001_fff1, 36'h0_0002_0000};
	mrp_core_model mrp_core_model_i (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_go(go), .i_req(req), .o_access(acc));
	mrp_region_protect mrp_region_protect_i (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_ce(1'b1), .i_unit_enable(unit_en),
		.i_privileged_background_map(bg), .i_protect_in_fault_handlers(pfh), .i_cfg_write(wr),
		.i_region_number(num), .i_cfg_region(cfg), .i_region_enable_set(es), .i_region_enable_clr(ec),
		.o_region_count(cnt), .o_cfg_region(rb), .i_access(acc), .o_access_done(done),
		.o_access_allowed(alw), .o_mem_fault(flt), .o_fault_addr(fa));
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic results;
		if (err_count == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic put(input logic [2:0] n, input logic [31:0] b, input mrp_attr_t a);
		@(posedge i_clk);
		num <= n;
		cfg <= {b, a};
		wr <= 1'b1;
		@(posedge i_clk);
		wr <= 1'b0;
	endtask
	task automatic pulse(input logic [2:0] n, input logic s);
		@(posedge i_clk);
		num <= n;
		es <= s;
		ec <= !s;
		@(posedge i_clk);
		es <= 1'b0;
		ec <= 1'b0;
	endtask
	task automatic hit(input logic [31:0] a, input logic [3:0] k);
		@(posedge i_clk);
		req <= '{valid: 1'b1, addr: a, write: k[3], fetch: k[2], priv: k[1], fault_handler: fh};
		go <= 1'b1;
		@(posedge i_clk);
		go <= 1'b0;
		@(posedge i_clk);
		@(negedge i_clk);
		chk(done, 1'b1);
		chk(alw, k[0]);
		chk(flt, !k[0]);
		if (!k[0]) chk(fa, a);
	endtask
	function automatic logic ok(input int c, input logic w, input logic p);
		return p ? (w ? c inside {1, 2, 3} : c inside {1, 2, 3, 5, 6}) : (w ? c == 3 : c inside {2, 3, 6});
	endfunction
	initial begin
		i_clk = 1'b0;
		forever #10 i_clk = ~i_clk;
	end
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 3000) begin
			err_count++;
			results;
		end
	end
	initial begin
		{i_arst_n, unit_en, bg, pfh, wr, es, ec, go, fh, num, cfg, req} = '0;
		repeat (5) @(posedge i_clk);
		i_arst_n <= 1'b1;
		@(negedge i_clk);
		chk(cnt, 4'h8);
		chk(rb, '0);
		@(posedge i_clk);
		unit_en <= 1'b1;
		pfh <= 1'b1;
		put(3'h7, 32'h0000_3000, {region_inactive, 8'hff, perm_priv_rw_user_rw, region_exec_allow, 5'h04});
		put(3'h1, 32'h0000_1400, {region_active, 8'h00, perm_priv_ro_user_ro, region_exec_deny, 5'h08});
		put(3'h0, 32'h0000_1000, {region_active, 8'h04, perm_priv_rw_user_ro, region_exec_allow, 5'h0b});
		@(negedge i_clk);
		chk(rb, {32'h0000_1000, region_active, 8'h04, perm_priv_rw_user_ro, region_exec_allow, 5'h0b});
		foreach (ROWS[i]) hit(ROWS[i][35:4], ROWS[i][3:0]);
		for (int c = 0; c < 8; c++) begin
			put(3'h2, 32'h0000_8000, {region_inactive, 8'h00, 3'(c), region_exec_allow, 5'h04});
			pulse(3'h2, 1'b1);
			for (int m = 0; m < 4; m++) hit(32'h0000_8000, {m[1], 1'b0, m[0], ok(c, m[1], m[0])});
		end
		pulse(3'h7, 1'b1);
		hit(32'h0000_3000, 4'h9);
		pulse(3'h7, 1'b0);
		hit(32'h0000_3000, 4'h2);
		@(posedge i_clk);
		bg <= 1'b1;
		hit(32'h0000_4000, 4'h3);
		hit(32'h0000_4000, 4'h0);
		@(posedge i_clk);
		pfh <= 1'b0;
		fh <= 1'b1;
		hit(32'h0000_4000, 4'h1);
		@(posedge i_clk);
		pfh <= 1'b1;
		hit(32'h0000_4000, 4'h0);
		put(3'h3, 32'h0000_0000, {region_active, 8'h00, perm_priv_none_user_none, region_exec_allow, 5'h1f});
		hit(32'h0000_4000, 4'h2);
		@(posedge i_clk);
		unit_en <= 1'b0;
		hit(32'h0000_4000, 4'h9);
		results;
	end
endmodule
